// ### src/fsh_host.sv
// Host controller that drives the supplementary flash command set
// Contract
// - Lock query: unlock AA,55,90 then read word 03 gives lock code.
// - Protect verify: read sector base plus 02 returns 00 or 01.
// - Page program is word width only, 35 writes, setup code C0.
// - Entry sequence ending in 88 maps security sector over boot sectors.
// - Mapping holds until exit sequence unlock,90,00 or power removal; the host also drops it after FC_HRST and on accepting FC_WAKE.
// - Acceleration voltage is applied only during accelerated programming.
// - Security sector protected by entry sequence then in-system protect flow.
// - Identification voltage on address bit nine, bits 1,0 high, reads lock code.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`include "fsh_defs.svh"
module fsh_host
	import fsh_pkg::*;
#(
	parameter bit TOP_BOOT      = 1'b0,
	parameter int PP_MAX_CYC    = (`FSH_PP_MAX_US * 1000) / `FSH_CLK_NS,
	parameter int PPACC_MAX_CYC = (`FSH_PPACC_MAX_US * 1000) / `FSH_CLK_NS
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Software register port
	input  wire logic [2:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Flash pins
	output fsh_pins_t        flash_pins,
	input  wire logic [15:0] flash_dq_in,
	output logic             flash_rst_n,
	output logic             width_sel,
	output logic             accel_voltage_pin,
	output logic             ident_high_voltage
);
	localparam int HV_CYC = (`FSH_HV_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS;
	localparam int RST_CYC = (`FSH_RST_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS;
	localparam int DRCV_CYC = (`FSH_DRCV_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS;
	localparam int STB_CYC = (`FSH_STB_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS;

	fsh_st_t     st;
	fsh_cmd_t    cmd;
	fsh_cmd_t    wcmd;
	fsh_step_t   stp;
	fsh_stat_t   stat;
	logic [5:0]  step;
	logic [15:0] timer;
	logic [15:0] pre;
	logic [15:0] poll_cnt;
	logic [15:0] lim;
	logic [19:0] addr_q;
	logic [15:0] data_q;
	logic [15:0] pbuf [32];
	logic [4:0]  pptr;
	logic [4:0]  pidx;
	logic [15:0] code3;
	logic [19:0] rd_adr;
	logic        tog_prev;
	logic        secure;
	logic        pdown;
	logic        lvalid;
	logic        lorg;
	logic        lcust;
	logic        prot;
	logic        tmo;
	logic        refused;
	logic        ctrl_wr;
	logic        refuse_c;
	logic        go;
	logic        unl;
	logic        polling;
	logic        cyc_start;
	logic        cyc_done;
	logic [15:0] cyc_rdata;
	logic        rdone;
	logic        tmo_hit;
	logic        fin;

	// Command acceptance and refusal
	assign wcmd = fsh_cmd_t'(reg_wdata[`FSH_CMD_MSB:0]);
	assign ctrl_wr = reg_wr && reg_addr == `FSH_CTRL;
	assign refuse_c = st != S_IDLE || reg_wdata[`FSH_CMD_MSB:0] > `FSH_CMD_MAX
		|| wcmd == FC_NONE
		|| (pdown && !(wcmd inside {FC_WAKE, FC_HRST}))
		|| (wcmd == FC_PAGE && secure && lvalid && (lorg || lcust))
		|| (wcmd == FC_READ && secure && addr_q[19:7] != 13'h0);
	assign go = ctrl_wr && !refuse_c;

	// Sequence bookkeeping
	assign unl = cmd inside {FC_LOCKQ, FC_PVER, FC_DPD, FC_PAGE, FC_SECIN, FC_SECOUT};
	assign polling = cmd == FC_PAGE && step >= `FSH_PP_LAST;
	assign pidx = 5'(step - 6'd3);
	assign cyc_start = st == S_ISSUE && stp.kind != K_END;
	assign rdone = st == S_WAIT && cyc_done && stp.kind == K_RD;
	assign lim = accel_voltage_pin ? 16'(PPACC_MAX_CYC) : 16'(PP_MAX_CYC);
	assign tmo_hit = st == S_WAIT && cyc_done && polling && poll_cnt >= lim;
	assign fin = (st == S_ISSUE && stp.kind == K_END) || tmo_hit;
	assign stat = '{accel: accel_voltage_pin, protect: prot, lock_origin_bit: lorg,
		customer_lock_bit: lcust, lock_valid: lvalid, powered_down: pdown,
		secure: secure, refused: refused, timeout: tmo, busy: st != S_IDLE};

	// Security reads go to the serial-number sector base
	assign rd_adr = secure ? ((TOP_BOOT ? `FSH_ESN_TOP : `FSH_ESN_BOT)
		| {13'h0, addr_q[6:0]}) : addr_q;

	// Wait before the first step: voltage settle, reset pulse, recovery
	always_comb
	begin
		pre = 16'h0;
		if (wcmd == FC_HVLOCK || (wcmd == FC_PAGE && reg_wdata[`FSH_ACC_BIT] && !secure))
			pre = 16'(HV_CYC);
		else if (wcmd == FC_HRST)
			pre = 16'(RST_CYC);
		else if (wcmd == FC_WAKE)
			pre = 16'(DRCV_CYC);
	end

	// Third unlock write carries the command code
	always_comb
	begin
		code3 = `FSH_AUTOSEL;
		if (cmd == FC_DPD)
			code3 = `FSH_DPD_DAT;
		else if (cmd == FC_PAGE)
			code3 = `FSH_PG_DAT;
		else if (cmd == FC_SECIN)
			code3 = `FSH_SECIN_DAT;
	end

	// Bus step for the current command and step index
	always_comb
	begin
		stp = fsh_mk(K_END, 20'h0, 16'h0);
		if (unl && step == 6'd0)
			stp = fsh_mk(K_WR, `FSH_U1_ADR, `FSH_U1_DAT);
		else if (unl && step == 6'd1)
			stp = fsh_mk(K_WR, `FSH_U2_ADR, `FSH_U2_DAT);
		else if (unl && step == 6'd2)
			stp = fsh_mk(K_WR, `FSH_U1_ADR, code3);
		else
			unique case (cmd)
			FC_READ:
				if (step == 6'd0)
					stp = fsh_mk(K_RD, rd_adr, 16'h0);
			FC_LOCKQ:
				if (step == 6'd3)
					stp = fsh_mk(K_RD, `FSH_LOCK_OFS, 16'h0);
				else if (step == 6'd4)
					stp = fsh_mk(K_WR, 20'h0, `FSH_RESET_DAT);
			FC_PVER:
				if (step == 6'd3)
					stp = fsh_mk(K_RD, {addr_q[19:12], `FSH_PROT_OFS}, 16'h0);
				else if (step == 6'd4)
					stp = fsh_mk(K_WR, 20'h0, `FSH_RESET_DAT);
			FC_PAGE:
				if (step < `FSH_PP_LAST)
					stp = fsh_mk(K_WR, {addr_q[19:5], pidx}, pbuf[pidx]);
				else if (step <= `FSH_PP_POLL2)
					stp = fsh_mk(K_RD, {addr_q[19:5], 5'h0}, 16'h0);
			FC_SECOUT:
				if (step == 6'd3)
					stp = fsh_mk(K_WR, 20'h0, `FSH_SECOUT_DAT);
			FC_HVLOCK:
				if (step == 6'd0)
					stp = fsh_mk(K_RD, `FSH_LOCK_OFS, 16'h0);
			default: ;
			endcase
	end

	// Main sequencer
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= S_IDLE;
			cmd <= FC_NONE;
			step <= 6'd0;
			timer <= 16'h0;
			poll_cnt <= 16'h0;
			tog_prev <= 1'b0;
		end
		else
		begin
			if (polling && st != S_IDLE)
				poll_cnt <= poll_cnt + 16'h1;
			if (rdone && polling)
				tog_prev <= cyc_rdata[`FSH_TOG_BIT];
			unique case (st)
			S_IDLE:
				if (go)
				begin
					cmd <= wcmd;
					step <= 6'd0;
					timer <= pre;
					poll_cnt <= 16'h0;
					st <= S_TIME;
				end
			S_TIME:
				if (timer == 16'h0)
					st <= S_ISSUE;
				else
					timer <= timer - 16'h1;
			S_ISSUE:
				st <= (stp.kind == K_END) ? S_IDLE : S_WAIT;
			S_WAIT:
				if (tmo_hit)
					st <= S_IDLE;
				else if (cyc_done)
				begin
					st <= S_ISSUE;
					// Stay on the second poll read while bit 6 still toggles
					if (!(polling && step == `FSH_PP_POLL2 && cyc_rdata[`FSH_TOG_BIT] != tog_prev))
						step <= step + 6'd1;
				end
			endcase
		end
	end

	// Reset, acceleration and identification voltage pins
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			flash_rst_n <= 1'b1;
			width_sel <= 1'b1;
			accel_voltage_pin <= 1'b0;
			ident_high_voltage <= 1'b0;
		end
		else
		begin
			width_sel <= 1'b1;
			if (go && wcmd == FC_HRST)
				flash_rst_n <= 1'b0;
			else if (go && wcmd == FC_WAKE)
				flash_rst_n <= 1'b1;
			else if (fin && cmd == FC_HRST)
				flash_rst_n <= 1'b1;
			else if (fin && cmd == FC_DPD)
				flash_rst_n <= 1'b0;
			if (go && wcmd == FC_PAGE)
				accel_voltage_pin <= reg_wdata[`FSH_ACC_BIT] && !secure;
			else if (fin)
				accel_voltage_pin <= 1'b0;
			if (go && wcmd == FC_HVLOCK)
				ident_high_voltage <= 1'b1;
			else if (fin)
				ident_high_voltage <= 1'b0;
		end
	end

	// Mode tracking: security mapping and deep power-down
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			secure <= 1'b0;
			pdown <= 1'b0;
		end
		else
		begin
			if (fin && cmd == FC_SECIN)
				secure <= 1'b1;
			else if (fin && cmd inside {FC_SECOUT, FC_HRST})
				secure <= 1'b0;
			else if (go && wcmd == FC_WAKE)
				secure <= 1'b0;
			if (fin && cmd == FC_DPD)
				pdown <= 1'b1;
			else if (go && wcmd inside {FC_WAKE, FC_HRST})
				pdown <= 1'b0;
		end
	end

	// Read results and status flags
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			data_q <= 16'h0;
			lvalid <= 1'b0;
			lorg <= 1'b0;
			lcust <= 1'b0;
			prot <= 1'b0;
			tmo <= 1'b0;
			refused <= 1'b0;
		end
		else
		begin
			if (rdone && !polling)
				data_q <= cyc_rdata;
			if (rdone && cmd inside {FC_LOCKQ, FC_HVLOCK})
			begin
				lvalid <= 1'b1;
				lorg <= cyc_rdata[`FSH_ORG_BIT];
				lcust <= cyc_rdata[`FSH_CUST_BIT];
			end
			if (rdone && cmd == FC_PVER)
				prot <= cyc_rdata[0];
			if (tmo_hit)
				tmo <= 1'b1;
			else if (go)
				tmo <= 1'b0;
			if (ctrl_wr)
				refused <= refuse_c;
		end
	end

	// Address register and page buffer pointer
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			addr_q <= 20'h0;
			pptr <= 5'h0;
		end
		else if (reg_wr && reg_addr == `FSH_ADDR)
		begin
			addr_q <= reg_wdata[19:0];
			pptr <= 5'h0;
		end
		else if (reg_wr && reg_addr == `FSH_PAGE && st == S_IDLE)
			pptr <= pptr + 5'h1;
	end

	// Page buffer words
	always_ff @(posedge core_clk)
	begin
		if (reg_wr && reg_addr == `FSH_PAGE && st == S_IDLE)
			pbuf[pptr] <= reg_wdata[15:0];
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h0;
		else if (reg_rd)
			case (reg_addr)
			`FSH_CTRL: reg_rdata <= {28'h0, cmd};
			`FSH_ADDR: reg_rdata <= {12'h0, addr_q};
			`FSH_DATA: reg_rdata <= {16'h0, data_q};
			`FSH_STAT: reg_rdata <= {22'h0, stat};
			`FSH_PAGE: reg_rdata <= {27'h0, pptr};
			default: reg_rdata <= 32'h0;
			endcase
		else
			reg_rdata <= 32'h0;
	end

	// Flash bus cycle engine
	fsh_cyc #(
		.STB_CYC (STB_CYC)
	) u_cyc (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (cyc_start),
		.rd       (stp.kind == K_RD),
		.addr     (stp.addr),
		.wdata    (stp.data),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.dq_in    (flash_dq_in),
		.pins     (flash_pins)
	);

	// Helper counters for the checks below
	logic [5:0]  wr_cnt;
	logic [15:0] rcv_cnt;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_cnt <= 6'd0;
			rcv_cnt <= 16'(DRCV_CYC);
		end
		else
		begin
			if (go)
				wr_cnt <= 6'd0;
			else if (cyc_start && stp.kind == K_WR)
				wr_cnt <= wr_cnt + 6'd1;
			if (go && wcmd == FC_WAKE)
				rcv_cnt <= 16'h0;
			else if (rcv_cnt < 16'(DRCV_CYC))
				rcv_cnt <= rcv_cnt + 16'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_lock_addr;
		cyc_start && stp.kind == K_RD && cmd == FC_LOCKQ |-> ##1 flash_pins.addr == 20'h00003;
	endproperty
	a_lock_addr: assert property (p_lock_addr) else $error("lock query address wrong");
	property p_prot_addr;
		cyc_start && stp.kind == K_RD && cmd == FC_PVER
			|-> ##1 flash_pins.addr == {addr_q[19:12], 12'h002};
	endproperty
	a_prot_addr: assert property (p_prot_addr) else $error("verify address wrong");
	property p_pp_count;
		st == S_ISSUE && cmd == FC_PAGE && step == 6'd35 |-> wr_cnt == 6'd35 && width_sel;
	endproperty
	a_pp_count: assert property (p_pp_count) else $error("page write count wrong");
	property p_acc_only;
		accel_voltage_pin |-> cmd == FC_PAGE && st != S_IDLE && !secure;
	endproperty
	a_acc_only: assert property (p_acc_only) else $error("accel voltage misused");
	property p_sec_exit;
		$fell(secure) |-> $past(cmd) inside {FC_SECOUT, FC_HRST} || $past(go);
	endproperty
	a_sec_exit: assert property (p_sec_exit) else $error("security map dropped");
	property p_sec_enter;
		$rose(secure) |-> $past(cmd) == FC_SECIN && $past(st) == S_ISSUE;
	endproperty
	a_sec_enter: assert property (p_sec_enter) else $error("security map set wrongly");
	property p_hrst;
		st == S_ISSUE && cmd == FC_HRST |=> !secure && flash_rst_n;
	endproperty
	a_hrst: assert property (p_hrst) else $error("reset left security map");
	property p_recover;
		cyc_start |-> rcv_cnt == 16'(DRCV_CYC);
	endproperty
	a_recover: assert property (p_recover) else $error("access during recovery");
	property p_ident;
		ident_high_voltage && !flash_pins.oe_n |-> flash_pins.we_n && flash_pins.addr == 20'h00003;
	endproperty
	a_ident: assert property (p_ident) else $error("ident read wrong");
	property p_pp_timeout;
		st == S_WAIT && polling && poll_cnt > lim |-> ##[0:20] st == S_IDLE;
	endproperty
	a_pp_timeout: assert property (p_pp_timeout) else $error("poll overran limit");

	c_page: cover property (st == S_ISSUE && cmd == FC_PAGE && stp.kind == K_END);
	c_lock: cover property (rdone && cmd == FC_LOCKQ);
	c_secin: cover property ($rose(secure));
	c_wake: cover property (fin && cmd == FC_WAKE);
endmodule

// ### src/fsh_defs.svh
// Offsets, command codes, field positions and timing for the flash host
`ifndef FSH_DEFS_SVH
`define FSH_DEFS_SVH
// Software register offsets
`define FSH_CTRL 3'h0
`define FSH_ADDR 3'h1
`define FSH_DATA 3'h2
`define FSH_STAT 3'h3
`define FSH_PAGE 3'h4
// Control register fields
`define FSH_CMD_MSB 3
`define FSH_ACC_BIT 4
`define FSH_CMD_MAX 4'ha
// Flash command words
`define FSH_U1_ADR 20'h00555
`define FSH_U2_ADR 20'h002aa
`define FSH_U1_DAT 16'h00aa
`define FSH_U2_DAT 16'h0055
`define FSH_AUTOSEL 16'h0090
`define FSH_DPD_DAT 16'h0050
`define FSH_PG_DAT 16'h00c0
`define FSH_SECIN_DAT 16'h0088
`define FSH_SECOUT_DAT 16'h0000
`define FSH_RESET_DAT 16'h00f0
// Flash addresses and data fields
`define FSH_LOCK_OFS 20'h00003
`define FSH_PROT_OFS 12'h002
`define FSH_ESN_BOT 20'h00000
`define FSH_ESN_TOP 20'hfff80
`define FSH_ORG_BIT 7
`define FSH_CUST_BIT 6
`define FSH_TOG_BIT 6
`define FSH_PP_LAST 6'd35
`define FSH_PP_POLL2 6'd36
// Timing
`define FSH_CLK_NS 50
`define FSH_STB_NS 100
`define FSH_HV_NS 500
`define FSH_RST_NS 500
`define FSH_DRCV_NS 20000
`define FSH_PP_MAX_US 510
`define FSH_PPACC_MAX_US 210
`endif

// ### src/fsh_pkg.sv
// Types shared by the flash extra-command host
package fsh_pkg;
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic        dq_oe;
	} fsh_pins_t;
	typedef enum logic [3:0] {
		FC_NONE = 4'h0, FC_READ = 4'h1, FC_LOCKQ = 4'h2, FC_PVER = 4'h3,
		FC_DPD = 4'h4, FC_WAKE = 4'h5, FC_PAGE = 4'h6, FC_SECIN = 4'h7,
		FC_SECOUT = 4'h8, FC_HRST = 4'h9, FC_HVLOCK = 4'ha
	} fsh_cmd_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_TIME = 2'b01, S_ISSUE = 2'b10,
		S_WAIT = 2'b11} fsh_st_t;
	typedef enum logic [1:0] {P_IDLE = 2'b00, P_SET = 2'b01, P_STB = 2'b10,
		P_HLD = 2'b11} fsh_ph_t;
	typedef enum logic [1:0] {K_END = 2'b00, K_WR = 2'b01, K_RD = 2'b10} fsh_kind_t;
	typedef struct packed {
		fsh_kind_t   kind;
		logic [19:0] addr;
		logic [15:0] data;
	} fsh_step_t;
	typedef struct packed {
		logic accel;
		logic protect;
		logic lock_origin_bit;
		logic customer_lock_bit;
		logic lock_valid;
		logic powered_down;
		logic secure;
		logic refused;
		logic timeout;
		logic busy;
	} fsh_stat_t;
	// Builds one bus step
	function automatic fsh_step_t fsh_mk(input fsh_kind_t k, input logic [19:0] a,
		input logic [15:0] d);
		fsh_mk = '{kind: k, addr: a, data: d};
	endfunction
endpackage

// ### src/fsh_cyc.sv
// One asynchronous flash bus cycle, write or read
`include "fsh_defs.svh"
module fsh_cyc
	import fsh_pkg::*;
#(
	parameter int STB_CYC = 2
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Request
	input  wire logic        start,
	input  wire logic        rd,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] wdata,
	output logic             done,
	output logic [15:0]      rdata,
	// Flash pins
	input  wire logic [15:0] dq_in,
	output fsh_pins_t        pins
);
	fsh_ph_t    ph;
	logic       rd_q;
	logic [3:0] cnt;

	// Address and select first, strobe next, select released after strobe
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ph <= P_IDLE;
			pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h0, dq_out: 16'h0,
				dq_oe: 1'b0};
			done <= 1'b0;
			rdata <= 16'h0;
			rd_q <= 1'b0;
			cnt <= 4'h0;
		end
		else
		begin
			done <= 1'b0;
			unique case (ph)
			P_IDLE:
				if (start)
				begin
					pins.ce_n <= 1'b0;
					pins.addr <= addr;
					pins.dq_out <= wdata;
					pins.dq_oe <= !rd;
					rd_q <= rd;
					ph <= P_SET;
				end
			P_SET:
			begin
				pins.we_n <= rd_q;
				pins.oe_n <= !rd_q;
				cnt <= 4'(STB_CYC - 1);
				ph <= P_STB;
			end
			P_STB:
				if (cnt == 4'h0)
				begin
					pins.we_n <= 1'b1;
					pins.oe_n <= 1'b1;
					if (rd_q)
						rdata <= dq_in;
					ph <= P_HLD;
				end
				else
					cnt <= cnt - 4'h1;
			P_HLD:
			begin
				pins.ce_n <= 1'b1;
				pins.dq_oe <= 1'b0;
				done <= 1'b1;
				ph <= P_IDLE;
			end
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Data still driven and unchanged as the write strobe rises
	property p_data_hold;
		$rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out) && !pins.ce_n;
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise");
	// Address steady and select low throughout a write strobe
	property p_addr_hold;
		!pins.we_n |-> $stable(pins.addr) && !pins.ce_n && $past(!pins.ce_n);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
endmodule

// ### tb/fsh_flash_model.sv
// Behavioural flash part that answers the host's supplementary commands
module fsh_flash_model
	import fsh_pkg::*;
#(
	parameter logic [7:0] LOCK_CODE = 8'h42,
	parameter logic [7:0] PROT_SA   = 8'h05
)
(
	// Pins from the host, and the bench's slow-programming select
	input  wire fsh_pins_t   pins,
	input  wire logic        rst_n,
	input  wire logic        accel,
	input  wire logic        ident,
	input  wire logic        slow,
	// Data back to the host
	output logic [15:0]      dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [19:0] la;
	logic [15:0] val;
	logic [15:0] last = 16'h0000;
	logic [15:0] mem [32];
	logic [14:0] pbase;
	logic        wact, asel, sec, pg, dpd;
	logic        tog = 1'b0;
	int          ucnt, pcnt, busy;
	realtime     t_up = 0.0;
	// Command decoder, one write at a time
	task automatic decode(input logic [19:0] a, input logic [15:0] d);
		if (pg)
		begin
			if (pcnt == 0)
				pbase = a[19:5];
			mem[a[4:0]] = d;
			pcnt++;
			if (pcnt == 32)
			begin
				pg = 1'b0;
				busy = slow ? 4000 : 3;
			end
		end
		else if (asel)
		begin
			asel = 1'b0;
			if (d == 16'h0000)
				sec = 1'b0;
		end
		else if (ucnt == 0)
			ucnt = (a == 20'h00555 && d == 16'h00aa) ? 1 : 0;
		else if (ucnt == 1)
			ucnt = (a == 20'h002aa && d == 16'h0055) ? 2 : 0;
		else
		begin
			ucnt = 0;
			pcnt = 0;
			asel = (d == 16'h0090);
			dpd = (d == 16'h0050);
			sec = sec | (d == 16'h0088);
			pg = (d == 16'h00c0) && !(sec && LOCK_CODE[7:6] != 2'b00);
		end
	endtask
	// Address latch on the later falling strobe
	always @(negedge pins.we_n or negedge pins.ce_n)
		if (!pins.we_n && !pins.ce_n)
		begin
			la = pins.addr;
			wact = 1'b1;
		end
	// Data latch on the first rising strobe
	always @(posedge pins.we_n or posedge pins.ce_n)
		if (wact && rst_n)
		begin
			wact = 1'b0;
			decode(la, pins.dq_out);
		end
	// Hardware reset returns to array reads, with recovery after power-down
	always @(rst_n)
	begin
		if (rst_n && dpd)
			t_up = $realtime + 20000.0;
		// Power-down is remembered through the low phase so recovery starts at the rise
		if (rst_n)
			dpd = 1'b0;
		{asel, sec, pg, wact} = 4'h0;
		ucnt = 0;
		busy = 0;
	end
	// Read data selection
	always @*
	begin
		if (ident && pins.addr[1:0] == 2'b11)
			val = {8'h00, LOCK_CODE};
		else if (dpd || $realtime < t_up)
			val = ~last;
		else if (busy > 0)
			val = {9'h000, tog, 6'h00};
		else if (asel && pins.addr[7:0] == 8'h03)
			val = {8'h00, LOCK_CODE};
		else if (asel && pins.addr[7:0] == 8'h02)
			val = {15'h0000, pins.addr[19:12] == PROT_SA && !accel};
		else if (sec && pins.addr[19:7] == 13'h0000)
			val = 16'he500 + {9'h000, pins.addr[6:0]};
		else if (pins.addr[19:5] == pbase)
			val = mem[pins.addr[4:0]];
		else
			val = pins.addr[15:0] ^ 16'h5a5a;
	end
	// Toggle bit advances once per read while programming
	always @(posedge pins.oe_n)
	begin
		last = val;
		if (busy > 0)
		begin
			busy--;
			tog = ~tog;
		end
	end
	// Released bus shows the inverse of the last value
	assign dq = (!pins.ce_n && !pins.oe_n) ? val : ~last;
endmodule

// ### tb/test_fsh_host.sv
// Self-checking bench for the flash extra-command host
`include "fsh_defs.svh"
module test_fsh_host
	import fsh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
		$display("Error %s expected %h seen %h", nm, exp, got); end end
	logic        core_clk, rst, reg_wr, reg_rd, slow;
	logic [2:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	fsh_pins_t   pins;
	logic [15:0] dq;
	logic        frst_n, wsel, accv, idv;
	int          n_errors, checks_done, cyc, acc_cyc, ac1;
	// Design and partner
	fsh_host #(.PP_MAX_CYC(600), .PPACC_MAX_CYC(400)) dut_u (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .flash_pins(pins), .flash_dq_in(dq), .flash_rst_n(frst_n),
		.width_sel(wsel), .accel_voltage_pin(accv), .ident_high_voltage(idv));
	fsh_flash_model flash_u (.pins(pins), .rst_n(frst_n), .accel(accv), .ident(idv),
		.slow(slow), .dq(dq));
	// Clock
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Verdict and end of run
	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard and high-voltage usage count
	always @(posedge core_clk)
	begin
		cyc++;
		if (accv)
			acc_cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			close_out();
		end
	end
	task automatic wr(input logic [2:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#10 v = reg_rdata;
	endtask
	// Issue a command and poll until idle; d ends with the status
	task automatic run(input logic [31:0] c);
		int n;
		wr(`FSH_CTRL, c);
		n = 0;
		d = 32'h1;
		while (d[0] !== 1'b0 && n < 3000)
		begin
			rd(`FSH_STAT, d);
			n++;
		end
		if (n == 3000)
		begin
			n_errors++;
			close_out();
		end
	endtask
	// Read one flash word through the host
	task automatic rdw(input logic [19:0] a, input logic [15:0] e);
		wr(`FSH_ADDR, {12'h000, a});
		run(32'h1);
		rd(`FSH_DATA, d);
		`CHK("word", d[15:0], e)
	endtask
	// Load a page at word 40 and program it
	task automatic page(input logic [31:0] c, input logic [31:0] t);
		wr(`FSH_ADDR, 32'h00040);
		for (int i = 0; i < 32; i++)
			wr(`FSH_PAGE, t + i);
		run(c);
	endtask
	// Main sequence
	initial
	begin
		{rst, reg_wr, reg_rd, slow} = 4'b1000;
		reg_addr = 3'h0;
		reg_wdata = 32'h0;
		n_errors = 0;
		checks_done = 0;
		cyc = 0;
		acc_cyc = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		rd(`FSH_STAT, d);
		`CHK("stat_reset", d, 32'h0)
		rd(3'h6, d);
		`CHK("unmapped", d, 32'h0)
		`CHK("width", {wsel, frst_n}, 2'b11)
		run(32'h2);
		`CHK("lockq", {d[7:5], d[2]}, 4'b0110)
		rd(`FSH_DATA, d);
		`CHK("lock_word", d[7:0], 8'h42)
		wr(`FSH_ADDR, 32'h05abc);
		run(32'h3);
		`CHK("pver_prot", d[8], 1'b1)
		wr(`FSH_ADDR, 32'h06000);
		run(32'h3);
		`CHK("pver_open", d[8], 1'b0)
		page(32'h6, 32'hc300);
		`CHK("page", d[2:0], 3'b000)
		rdw(20'h00040, 16'hc300);
		rdw(20'h0005f, 16'hc31f);
		page(32'h16, 32'h7100);
		`CHK("acc_page", {d[9], d[2:0], accv}, 5'h00)
		`CHK("acc_used", acc_cyc > 0, 1'b1)
		ac1 = acc_cyc;
		rdw(20'h0004f, 16'h710f);
		run(32'h7);
		`CHK("sec_in", d[3], 1'b1)
		rdw(20'h00003, 16'he503);
		wr(`FSH_ADDR, 32'h00080);
		run(32'h1);
		`CHK("sec_range", d[2], 1'b1)
		run(32'h6);
		`CHK("sec_page", d[2], 1'b1)
		run(32'h8);
		`CHK("sec_out", d[3], 1'b0)
		rdw(20'h00003, 16'h5a59);
		slow <= 1'b1;
		page(32'h6, 32'h0);
		`CHK("pp_timeout", d[1], 1'b1)
		slow <= 1'b0;
		run(32'h7);
		run(32'h9);
		`CHK("hrst", {d[3], frst_n}, 2'b01)
		rdw(20'h00003, 16'h5a59);
		run(32'h4);
		`CHK("dpd", {d[4], frst_n}, 2'b10)
		run(32'h2);
		`CHK("dpd_refuse", d[2], 1'b1)
		run(32'h5);
		`CHK("wake", {d[4], frst_n}, 2'b01)
		run(32'h2);
		rd(`FSH_DATA, d);
		`CHK("wake_read", d[7:0], 8'h42)
		rdw(20'h00003, 16'h5a59);
		run(32'ha);
		`CHK("hv_lock", {d[7:5], idv}, 4'b0110)
		rd(`FSH_DATA, d);
		`CHK("hv_word", d[7:0], 8'h42)
		run(32'h0);
		`CHK("bad_cmd0", d[2], 1'b1)
		run(32'hb);
		`CHK("bad_cmdb", d[2], 1'b1)
		`CHK("acc_only", acc_cyc, ac1)
		close_out();
	end
endmodule
